/* File: core/irq_port_pkg.sv */
package irq_port_pkg;

   // Register byte addresses on the bus (index times four)
   localparam logic [7:0]  IDX_CTRL_BANK0 = 8'h0b;
   localparam logic [7:0]  IDX_CTRL_BANK1 = 8'h8b;
   localparam logic [11:0] ADDR_CTRL0     = {2'b00, IDX_CTRL_BANK0, 2'b00};
   localparam logic [11:0] ADDR_CTRL1     = {2'b00, IDX_CTRL_BANK1, 2'b00};
   localparam logic [11:0] ADDR_PORT      = 12'h400;
   localparam logic [11:0] ADDR_RMW       = 12'h404;
   localparam logic [11:0] ADDR_LATCH     = 12'h408;
   localparam logic [11:0] ADDR_TIMER     = 12'h40c;
   localparam logic [11:0] ADDR_RETURN    = 12'h410;
   localparam logic [11:0] ADDR_EVT_STAT  = 12'h414;
   localparam logic [11:0] ADDR_EVT_MASK  = 12'h418;

   // Bit positions in the interrupt control register
   localparam int BIT_GIE  = 7;
   localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
   localparam int BIT_TIE  = 5;
   localparam int BIT_EIE  = 4;
   localparam int BIT_PCIE = 3;
   localparam int BIT_TF   = 2;
   localparam int BIT_EF   = 1;
   localparam int BIT_PCF  = 0;

   // Reset values and the timer maximum
   localparam logic [7:0] CTRL_RESET  = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] TIMER_RESET = 8'h00;
   localparam logic [7:0] TIMER_MAX   = 8'hff;
   localparam logic [2:0] EVT_RESET   = 3'h0;

   // Read-modify-write operations, carried in the write data
   typedef enum logic [1:0]
   {
      RMW_WRITE = 2'h0,
      RMW_CLEAR = 2'h1,
      RMW_SET   = 2'h2
   } rmw_op_t;

   // Pins seen by the block after synchronisation
   typedef struct packed
   {
      logic       ext_pin;
      logic [7:0] port_pins;
   } pins_t;

   // Edge detector states
   typedef enum logic [1:0]
   {
      EDGE_ARM  = 2'b01,
      EDGE_SEEN = 2'b10
   } edge_state_t;

endpackage

/* File: core/pin_sync.sv */
`timescale 1ns/1ps

// Two-stage synchroniser for asynchronous pin levels
module pin_sync
   import irq_port_pkg::*;
#(
   parameter int WIDTH = 9
)
(
   // Clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // Pins
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         meta_r   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule

/* File: core/irq_port_ctrl.sv */
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps

// What this block does
// - Each flag sets on its event whatever the enables and the global enable hold.
// - The interrupt control register is fully readable and writable with flags and enables.
// - The interrupt control register answers at two addresses that share one storage.
// - A change on any of the four upper port pins sets the port change flag until software clears it.
// - The external pin event sets its flag, which stays until software writes zero.
// - The timer overflow enable passes or masks the timer overflow interrupt.
// - The external pin enable passes or blocks the external pin interrupt.
// - Bit 3 is the port change enable and, together with the peripheral enable in bit 6, lets the port change flag interrupt.
// - A port read returns the pin levels, not the latch.
// - A port write stores the value into the output latch.
// - A bit set or clear reads the pins, modifies the value and writes it to the latch.
// - Port writes land at the end of the cycle while reads sample pins at its start.
// - The timer overflow flag sets when the count wraps from its maximum to zero.
// - Reset clears the global interrupt enable.
// - The return-from-interrupt operation sets the global interrupt enable.
module irq_port_ctrl
   import irq_port_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Pins and events
   input  wire logic [7:0]  port_pins,
   input  wire logic        external_interrupt_pin,
   input  wire logic        timer_tick,
   output logic      [7:0]  port_latch,
   output logic             core_irq,
   output logic             irq
);

   // All state of the block
   typedef struct packed
   {
      logic        dphase;
      logic        dwrite;
      logic [11:0] daddr;
      logic [7:0]  ctrl;
      logic [7:0]  latch;
      logic [7:0]  timer;
      logic [3:0]  upper_prev;
      edge_state_t ext_state;
      logic [2:0]  evt_stat;
      logic [2:0]  evt_mask;
      logic [31:0] rdata;
      logic        core_irq;
      logic        irq;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   pins_t  pins_s;

   // Pins cross into hclk before any logic sees them
   pin_sync #(.WIDTH(9)) u_sync
   (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in ({external_interrupt_pin, port_pins}),
      .sync_out (pins_s)
   );

   // Both bank addresses decode to the same storage
   function automatic logic is_ctrl(input logic [11:0] a);
      return (a == ADDR_CTRL0) || (a == ADDR_CTRL1);
   endfunction

   logic        addr_ok;
   logic        take;
   logic        wr_ctrl;
   logic [7:0]  wd8;
   logic        tick_wrap;
   logic        pc_evt;
   logic        ext_evt;
   logic [7:0]  rmw_val;
   logic [7:0]  nc;
   logic        req;
   logic [2:0]  raw_evt;

   always_comb
   begin
      addr_ok = 1'b0;
      rmw_val = 8'h00;
      nc      = 8'h00;
      req     = 1'b0;
      st_nxt  = st_r;
      take    = hsel && hready && htrans[1];
      wd8     = hwdata[7:0];

      // Address phase capture, data phase one cycle later
      st_nxt.dphase = take;
      st_nxt.dwrite = take && hwrite;
      st_nxt.daddr  = haddr;
      wr_ctrl = st_r.dphase && st_r.dwrite && is_ctrl(st_r.daddr);

      // Events
      tick_wrap = timer_tick && (st_r.timer == TIMER_MAX);
      pc_evt    = pins_s.port_pins[7:4] != st_r.upper_prev;
      ext_evt   = pins_s.ext_pin && (st_r.ext_state == EDGE_ARM);
      st_nxt.upper_prev = pins_s.port_pins[7:4];
      st_nxt.ext_state  = pins_s.ext_pin ? EDGE_SEEN : EDGE_ARM;
      if (timer_tick)
      begin
         st_nxt.timer = st_r.timer + 8'h01;
      end

      // Software write of the control register, then hardware sets win
      nc = st_r.ctrl;
      if (wr_ctrl)
      begin
         nc = wd8;
      end
      if (st_r.dphase && st_r.dwrite && st_r.daddr == ADDR_RETURN)
      begin
         nc[BIT_GIE] = 1'b1;
      end
      nc[BIT_TF]  = nc[BIT_TF]  | tick_wrap;
      nc[BIT_EF]  = nc[BIT_EF]  | ext_evt;
      nc[BIT_PCF] = nc[BIT_PCF] | pc_evt;
      st_nxt.ctrl = nc;

      // Port latch updates at the end of the write data phase
      if (st_r.dphase && st_r.dwrite)
      begin
         unique case (st_r.daddr)
            ADDR_PORT:  st_nxt.latch = wd8;
            ADDR_LATCH: st_nxt.latch = wd8;
            ADDR_TIMER: st_nxt.timer = wd8;
            ADDR_RMW:
            begin
               // Modify the pin levels, not the latch
               rmw_val = pins_s.port_pins;
               unique case (rmw_op_t'(hwdata[9:8]))
                  RMW_CLEAR: rmw_val[hwdata[2:0]] = 1'b0;
                  RMW_SET:   rmw_val[hwdata[2:0]] = 1'b1;
                  default:   rmw_val = wd8;
               endcase
               st_nxt.latch = rmw_val;
            end
            ADDR_EVT_MASK: st_nxt.evt_mask = wd8[2:0];
            default: ;
         endcase
      end

      // Sticky event status, write one to clear, set wins
      raw_evt = {tick_wrap, ext_evt, pc_evt};
      if (st_r.dphase && st_r.dwrite && st_r.daddr == ADDR_EVT_STAT)
      begin
         st_nxt.evt_stat = st_r.evt_stat & ~wd8[2:0];
      end
      st_nxt.evt_stat = st_nxt.evt_stat | raw_evt;

      // Read data prepared in the address phase; pins sampled at cycle start
      addr_ok = 1'b1;
      unique case (haddr)
         ADDR_CTRL0, ADDR_CTRL1: st_nxt.rdata = {24'h000000, nc};
         ADDR_PORT:     st_nxt.rdata = {24'h000000, pins_s.port_pins};
         ADDR_RMW:      st_nxt.rdata = {24'h000000, pins_s.port_pins};
         ADDR_LATCH:    st_nxt.rdata = {24'h000000, st_nxt.latch};
         ADDR_TIMER:    st_nxt.rdata = {24'h000000, st_nxt.timer};
         ADDR_EVT_STAT: st_nxt.rdata = {29'h0, st_nxt.evt_stat};
         ADDR_EVT_MASK: st_nxt.rdata = {29'h0, st_nxt.evt_mask};
         default:
         begin
            addr_ok      = 1'b0;
            st_nxt.rdata = 32'h00000000;
         end
      endcase
      if (!take || hwrite)
      begin
         st_nxt.rdata = 32'h00000000;
      end

      // Core request: peripheral source is gated by its own enable too
      req = (st_r.ctrl[BIT_TIE]  && st_r.ctrl[BIT_TF])
         || (st_r.ctrl[BIT_EIE]  && st_r.ctrl[BIT_EF])
         || (st_r.ctrl[BIT_PERIPHERAL_IRQ_ENABLE] && st_r.ctrl[BIT_PCIE] && st_r.ctrl[BIT_PCF]);
      st_nxt.core_irq = req && st_r.ctrl[BIT_GIE];
      st_nxt.irq      = |(st_nxt.evt_stat & st_nxt.evt_mask);
   end

   // One register bank for the whole state
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_r.dphase     <= 1'b0;
         st_r.dwrite     <= 1'b0;
         st_r.daddr      <= 12'h000;
         st_r.ctrl       <= CTRL_RESET;
         st_r.latch      <= LATCH_RESET;
         st_r.timer      <= TIMER_RESET;
         st_r.upper_prev <= 4'h0;
         st_r.ext_state  <= EDGE_ARM;
         st_r.evt_stat   <= EVT_RESET;
         st_r.evt_mask   <= EVT_RESET;
         st_r.rdata      <= 32'h00000000;
         st_r.core_irq   <= 1'b0;
         st_r.irq        <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign hrdata     = st_r.rdata;
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign port_latch = st_r.latch;
   assign core_irq   = st_r.core_irq;
   assign irq        = st_r.irq;

   logic unused_ok;
   assign unused_ok = addr_ok ^ (|hsize);

   // Flag stays set until software writes it to zero
   property p_ext_hold;
      @(posedge hclk) disable iff (!hresetn)
      (st_r.ctrl[BIT_EF] && !wr_ctrl) |=> st_r.ctrl[BIT_EF];
   endproperty
   a_ext_hold: assert property (p_ext_hold) else $error("ext flag lost");

   property p_wrap;
      @(posedge hclk) disable iff (!hresetn)
      (timer_tick && st_r.timer == TIMER_MAX && !(st_r.dphase && st_r.dwrite && st_r.daddr == ADDR_TIMER))
         |=> (st_r.ctrl[BIT_TF] && st_r.timer == 8'h00);
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap did not flag");

   property p_pc_set;
      @(posedge hclk) disable iff (!hresetn)
      (pins_s.port_pins[7:4] != st_r.upper_prev) |=> st_r.ctrl[BIT_PCF];
   endproperty
   a_pc_set: assert property (p_pc_set) else $error("port change missed");

   property p_flag_no_enable;
      @(posedge hclk) disable iff (!hresetn)
      (ext_evt && !st_r.ctrl[BIT_GIE]) |=> st_r.ctrl[BIT_EF];
   endproperty
   a_flag_no_enable: assert property (p_flag_no_enable) else $error("flag gated");

   property p_tmask;
      @(posedge hclk) disable iff (!hresetn)
      (!st_r.ctrl[BIT_TIE] && !st_r.ctrl[BIT_EF] && !st_r.ctrl[BIT_PCF]) |=> !core_irq;
   endproperty
   a_tmask: assert property (p_tmask) else $error("masked timer irq");

   property p_eirq;
      @(posedge hclk) disable iff (!hresetn)
      (st_r.ctrl[BIT_GIE] && st_r.ctrl[BIT_EIE] && st_r.ctrl[BIT_EF]) |=> core_irq;
   endproperty
   a_eirq: assert property (p_eirq) else $error("ext irq missing");

   property p_pcirq;
      @(posedge hclk) disable iff (!hresetn)
      (st_r.ctrl[BIT_GIE] && st_r.ctrl[BIT_PERIPHERAL_IRQ_ENABLE] && st_r.ctrl[BIT_PCIE] && st_r.ctrl[BIT_PCF]) |=> core_irq;
   endproperty
   a_pcirq: assert property (p_pcirq) else $error("port change irq missing");

   property p_gie;
      @(posedge hclk) disable iff (!hresetn)
      !st_r.ctrl[BIT_GIE] |=> !core_irq;
   endproperty
   a_gie: assert property (p_gie) else $error("irq without global enable");

   property p_port_wr;
      @(posedge hclk) disable iff (!hresetn)
      (st_r.dphase && st_r.dwrite && st_r.daddr == ADDR_PORT) |=> port_latch == $past(hwdata[7:0]);
   endproperty
   a_port_wr: assert property (p_port_wr) else $error("latch not written");

   property p_ret;
      @(posedge hclk) disable iff (!hresetn)
      (st_r.dphase && st_r.dwrite && st_r.daddr == ADDR_RETURN) |=> st_r.ctrl[BIT_GIE];
   endproperty
   a_ret: assert property (p_ret) else $error("return did not enable");

   // Flags hold until software writes the register
   property p_pcf_hold;
      @(posedge hclk) disable iff (!hresetn)
      (st_r.ctrl[BIT_PCF] && !wr_ctrl) |=> st_r.ctrl[BIT_PCF];
   endproperty
   a_pcf_hold: assert property (p_pcf_hold) else $error("port change flag lost");

   property p_tf_hold;
      @(posedge hclk) disable iff (!hresetn)
      (st_r.ctrl[BIT_TF] && !wr_ctrl) |=> st_r.ctrl[BIT_TF];
   endproperty
   a_tf_hold: assert property (p_tf_hold) else $error("timer flag lost");

   // Nothing but a wrap or software sets the timer flag
   property p_tf_only;
      @(posedge hclk) disable iff (!hresetn)
      (!st_r.ctrl[BIT_TF] && !tick_wrap && !wr_ctrl) |=> !st_r.ctrl[BIT_TF];
   endproperty
   a_tf_only: assert property (p_tf_only) else $error("timer flag without wrap");

   property p_evt_set;
      @(posedge hclk) disable iff (!hresetn)
      raw_evt[2] |=> st_r.evt_stat[2];
   endproperty
   a_evt_set: assert property (p_evt_set) else $error("wrap status missed");

   property p_tie_on;
      @(posedge hclk) disable iff (!hresetn)
      (st_r.ctrl[BIT_GIE] && st_r.ctrl[BIT_TIE] && st_r.ctrl[BIT_TF]) |=> core_irq;
   endproperty
   a_tie_on: assert property (p_tie_on) else $error("timer irq missing");

   // Enable bits follow a write through either bank address
   property p_alias;
      @(posedge hclk) disable iff (!hresetn)
      wr_ctrl |=> st_r.ctrl[7:3] == $past(hwdata[7:3]);
   endproperty
   a_alias: assert property (p_alias) else $error("control write lost");

   property p_port_rd;
      @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && haddr == ADDR_PORT) |=> hrdata == {24'h000000, $past(pins_s.port_pins)};
   endproperty
   a_port_rd: assert property (p_port_rd) else $error("port read not pins");

   property p_rmw_set;
      @(posedge hclk) disable iff (!hresetn)
      (st_r.dphase && st_r.dwrite && st_r.daddr == ADDR_RMW && hwdata[9:8] == RMW_SET)
         |=> port_latch == ($past(pins_s.port_pins) | (8'h01 << $past(hwdata[2:0])));
   endproperty
   a_rmw_set: assert property (p_rmw_set) else $error("bit set not from pins");

   // No disable here: it watches the release itself
   property p_gie_reset;
      @(posedge hclk)
      $rose(hresetn) |-> !st_r.ctrl[BIT_GIE];
   endproperty
   a_gie_reset: assert property (p_gie_reset) else $error("global enable after reset");

endmodule

/* File: dv/ahb_core_model.sv */
`timescale 1ns/1ps

// Core side of the register bus, one single transfer at a time
module ahb_core_model
(
   // Clock
   input  wire logic        hclk,
   // Request
   output logic             hsel,
   output logic      [11:0] haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [31:0] hwdata,
   // Answer
   input  wire logic        hreadyout,
   input  wire logic [31:0] hrdata
);
   logic hung;

   // Idle bus from time zero
   initial
   begin
      hung = 1'b0;
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
   end

   // Bounded wait for hready; data taken at the edge that samples it
   task automatic settle(output logic [31:0] got);
      int k;
      got = 32'h0;
      for (k = 0; k < 16; k++)
      begin
         @(posedge hclk);
         if (hreadyout === 1'b1)
         begin
            got = hrdata;
            break;
         end
      end
      if (k == 16)
         hung = 1'b1;
   endtask

   // Address phase, then data phase, each held until hready
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] got);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      settle(got);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      settle(got);
   endtask
endmodule

/* File: dv/interrupt_flags_and_port_latch_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_errors++; $display("mismatch %s expected %h seen %h", nm, e, s); end end

module interrupt_flags_and_port_latch_tb;
   import irq_port_pkg::*;

   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, tick, ext_pin, core_irq, irq;
   logic [1:0]  htrans;
   logic [11:0] haddr;
   logic [31:0] hwdata, hrdata, got;
   logic [7:0]  pins, latch;
   int          n_errors = 0;
   int          n_compared = 0;

   // 25 MHz clock
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   ahb_core_model ahb_core_model_i (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata));

   // Single slave, so its hreadyout is the bus hready
   irq_port_ctrl irq_port_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .port_pins(pins), .external_interrupt_pin(ext_pin), .timer_tick(tick), .port_latch(latch),
      .core_irq(core_irq), .irq(irq));

   // Shared helpers; irq_is checks on a falling edge where outputs are settled, rd at the rising edge that takes the data
   task automatic nap(input int n);
      repeat (n) @(negedge hclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      ahb_core_model_i.xfer(1'b1, a, d, got);
   endtask
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
      ahb_core_model_i.xfer(1'b0, a, 32'h0, got);
      `CHK(nm, e, got)
   endtask
   task automatic irq_is(input logic e);
      nap(2);
      `CHK("core_irq", e, core_irq)
   endtask

   task automatic t_reset;
      rd("ctrl", ADDR_CTRL0, 32'h0);
      `CHK("latch", 8'h00, latch)
      `CHK("hresp", 1'b0, hresp)
      `CHK("hreadyout", 1'b1, hreadyout)
      `CHK("core_irq", 1'b0, core_irq)
      `CHK("irq", 1'b0, irq)
      $display("test reset done");
   endtask

   task automatic t_ctrl;
      wr(ADDR_CTRL0, 32'h78);
      rd("ctrl alias", ADDR_CTRL1, 32'h78);
      wr(ADDR_CTRL1, 32'h0);
      rd("ctrl", ADDR_CTRL0, 32'h0);
      rd("unmapped", 12'h7f0, 32'h0);
      $display("test ctrl done");
   endtask

   // Wrap with every enable off, then the event layer and the control enables
   task automatic t_timer;
      wr(ADDR_EVT_STAT, 32'h7);
      wr(ADDR_TIMER, 32'hff);
      @(posedge hclk);
      tick <= 1'b1;
      @(posedge hclk);
      tick <= 1'b0;
      nap(2);
      rd("ctrl", ADDR_CTRL0, 32'h04);
      rd("timer", ADDR_TIMER, 32'h0);
      rd("evt", ADDR_EVT_STAT, 32'h4);
      `CHK("irq", 1'b0, irq)
      wr(ADDR_EVT_MASK, 32'h4);
      nap(2);
      `CHK("irq", 1'b1, irq)
      wr(ADDR_EVT_STAT, 32'h4);
      nap(2);
      `CHK("irq", 1'b0, irq)
      wr(ADDR_CTRL0, 32'ha4);
      irq_is(1'b1);
      wr(ADDR_CTRL0, 32'h84);
      irq_is(1'b0);
      wr(ADDR_CTRL0, 32'h0);
      $display("test timer done");
   endtask

   task automatic t_ext;
      @(posedge hclk);
      ext_pin <= 1'b1;
      nap(4);
      rd("ctrl", ADDR_CTRL0, 32'h02);
      wr(ADDR_CTRL0, 32'h92);
      irq_is(1'b1);
      wr(ADDR_CTRL0, 32'h82);
      irq_is(1'b0);
      wr(ADDR_CTRL0, 32'h0);
      rd("ctrl", ADDR_CTRL0, 32'h0);
      ext_pin <= 1'b0;
      $display("test ext done");
   endtask

   // Port change needs the peripheral enable as well
   task automatic t_change;
      @(posedge hclk);
      pins <= 8'h30;
      nap(4);
      rd("ctrl", ADDR_CTRL0, 32'h01);
      wr(ADDR_CTRL0, 32'h89);
      irq_is(1'b0);
      wr(ADDR_CTRL0, 32'hc9);
      irq_is(1'b1);
      wr(ADDR_CTRL0, 32'h0);
      rd("ctrl", ADDR_CTRL0, 32'h0);
      wr(ADDR_RETURN, 32'h0);
      rd("ctrl", ADDR_CTRL0, 32'h80);
      wr(ADDR_CTRL0, 32'h0);
      $display("test change done");
   endtask

   // Pins differ from the latch so reads and bit operations show their source
   task automatic t_port;
      @(posedge hclk);
      pins <= 8'h5a;
      nap(4);
      wr(ADDR_PORT, 32'h3c);
      nap(1);
      `CHK("latch", 8'h3c, latch)
      rd("port", ADDR_PORT, 32'h5a);
      wr(ADDR_RMW, 32'h200);
      nap(1);
      `CHK("latch", 8'h5b, latch)
      wr(ADDR_RMW, 32'h106);
      nap(1);
      `CHK("latch", 8'h1a, latch)
      wr(ADDR_RMW, 32'h0c3);
      nap(1);
      `CHK("latch", 8'hc3, latch)
      wr(ADDR_LATCH, 32'h66);
      rd("latch reg", ADDR_LATCH, 32'h66);
      rd("rmw pins", ADDR_RMW, 32'h5a);
      $display("test port done");
   endtask

   // Reset in mid-run drops the global enable that return set
   task automatic t_rst2;
      wr(ADDR_RETURN, 32'h0);
      rd("ctrl", ADDR_CTRL0, 32'h81);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      nap(1);
      `CHK("latch", 8'h00, latch)
      `CHK("core_irq", 1'b0, core_irq)
      ahb_core_model_i.xfer(1'b0, ADDR_CTRL0, 32'h0, got);
      `CHK("gie", 1'b0, got[BIT_GIE])
      $display("test mid reset done");
   endtask

   task automatic test_done;
      if (ahb_core_model_i.hung)
         n_errors++;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Reset, then the scenarios in turn
   initial
   begin
      pins = 8'h00;
      ext_pin = 1'b0;
      tick = 1'b0;
      hresetn = 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_ctrl;
      t_timer;
      t_ext;
      t_change;
      t_port;
      t_rst2;
      test_done;
   end

   // Cuts a hang short
   initial
   begin
      repeat (20000) @(posedge hclk);
      n_errors++;
      test_done;
   end
endmodule
